//--- csr_consts.vh
// constants for the charger status register bank
// Notes on behaviour
// R1: status one bit 0 shows port detection done
// R2: optimizer state 0 off,1 run,2 found,3 reserved
// R3: status two bit 2 shows thermal regulation
// R4: status two bit 1 shows data-line detection ongoing
// R5: status two bit 0 shows battery present
// R6: all four registers reset to zero
// R7: status three bit 7 input2 blocking pair fitted
// R8: status three bit 6 input1 blocking pair fitted
// R9: status three bit 5 one-shot conversion complete
// R10: status three bit 4 minimum system rail regulation
// R11: bits 3,2,1 fast, trickle, precharge timer expired
// R12: status four bit 4 battery too low boost
// R13: status four bit 3 thermistor cold
// R14: status four bit 2 thermistor cool
// R15: status four bit 1 thermistor warm
// R16: status four bit 0 thermistor hot
// R17: bits track live; writes change nothing
// R18: reserved bits and encoding never produced
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH
`define CSR_ADDR_W 8
`define CSR_OFS_ONE 8'h1c
`define CSR_OFS_TWO 8'h1d
`define CSR_OFS_THREE 8'h1e
`define CSR_OFS_FOUR 8'h1f
`define CSR_RESET 8'h00
`define CSR_ICO_OFF 2'h0
`define CSR_ICO_RUN 2'h1
`define CSR_ICO_FOUND 2'h2
`define CSR_ICO_RSVD 2'h3
`endif

//--- csr_status_bank.v
// read-only charger status register bank
`timescale 1ns/10ps
`include "csr_consts.vh"
module csr_status_bank (
  // clock and reset
  input wire mclk,
  input wire reset,
  // register port
  input wire regRead,
  input wire regWrite,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  output reg regRvalid,
  // conditions
  input wire portDetectComplete,
  input wire [1:0] optimizerState,
  input wire dieThermalRegulation,
  input wire dataLineDetectActive,
  input wire batteryPresent,
  input wire input2BlockingPairFitted,
  input wire input1BlockingPairFitted,
  input wire adcOneShotMode,
  input wire adcConversionDone,
  input wire forwardMode,
  input wire minSystemRailRegulation,
  input wire fastChargeTimerExpired,
  input wire trickleTimerExpired,
  input wire prechargeTimerExpired,
  input wire batteryTooLowForBoost,
  input wire thermistorCold,
  input wire thermistorCool,
  input wire thermistorWarm,
  input wire thermistorHot
);
  wire [7:0] liveOne;
  wire [7:0] liveTwo;
  wire [7:0] liveThree;
  wire [7:0] liveFour;
  reg [7:0] chargerStatusOne;
  reg [7:0] chargerStatusTwo;
  reg [7:0] chargerStatusThree;
  reg [7:0] chargerStatusFour;
  reg [7:0] next_regRdata;

  csr_status_pack packer (
    .portDetectComplete(portDetectComplete),
    .optimizerState(optimizerState),
    .dieThermalRegulation(dieThermalRegulation),
    .dataLineDetectActive(dataLineDetectActive),
    .batteryPresent(batteryPresent),
    .input2BlockingPairFitted(input2BlockingPairFitted),
    .input1BlockingPairFitted(input1BlockingPairFitted),
    .adcOneShotMode(adcOneShotMode),
    .adcConversionDone(adcConversionDone),
    .forwardMode(forwardMode),
    .minSystemRailRegulation(minSystemRailRegulation),
    .fastChargeTimerExpired(fastChargeTimerExpired),
    .trickleTimerExpired(trickleTimerExpired),
    .prechargeTimerExpired(prechargeTimerExpired),
    .batteryTooLowForBoost(batteryTooLowForBoost),
    .thermistorCold(thermistorCold),
    .thermistorCool(thermistorCool),
    .thermistorWarm(thermistorWarm),
    .thermistorHot(thermistorHot),
    .statusOne(liveOne),
    .statusTwo(liveTwo),
    .statusThree(liveThree),
    .statusFour(liveFour)
  );

  // status refreshed every cycle, writes ignored
  always @(posedge mclk) begin
    if (reset) begin
      chargerStatusOne <= `CSR_RESET; // R6
      chargerStatusTwo <= `CSR_RESET; // R6
      chargerStatusThree <= `CSR_RESET; // R6
      chargerStatusFour <= `CSR_RESET; // R6
    end else begin
      chargerStatusOne <= liveOne; // R17
      chargerStatusTwo <= liveTwo; // R17
      chargerStatusThree <= liveThree; // R17
      chargerStatusFour <= liveFour; // R17
    end
  end

  // read decode, unmapped reads zero
  always @* begin
    case (regAddr)
      `CSR_OFS_ONE: next_regRdata = chargerStatusOne;
      `CSR_OFS_TWO: next_regRdata = chargerStatusTwo;
      `CSR_OFS_THREE: next_regRdata = chargerStatusThree;
      `CSR_OFS_FOUR: next_regRdata = chargerStatusFour;
      default: next_regRdata = `CSR_RESET;
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      regRdata <= `CSR_RESET;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead & ~regWrite;
      if (regRead & ~regWrite) begin
        regRdata <= next_regRdata;
      end
    end
  end
endmodule

//--- csr_status_bank_monitor.sv
// assertions for the status register bank
`timescale 1ns/10ps
module csr_status_bank_monitor (
  // clock, reset and register port
  input wire mclk, input wire reset, input wire regRead, input wire regWrite,
  input wire [7:0] regAddr, input wire [7:0] regRdata, input wire regRvalid,
  // conditions
  input wire portDetectComplete, input wire [1:0] optimizerState,
  input wire dieThermalRegulation, input wire dataLineDetectActive, input wire batteryPresent,
  input wire input2BlockingPairFitted, input wire input1BlockingPairFitted,
  input wire adcOneShotMode, input wire adcConversionDone, input wire forwardMode,
  input wire minSystemRailRegulation, input wire fastChargeTimerExpired,
  input wire trickleTimerExpired, input wire prechargeTimerExpired,
  input wire batteryTooLowForBoost, input wire thermistorCold, input wire thermistorCool,
  input wire thermistorWarm, input wire thermistorHot
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_rd(a);
    regRead && !regWrite && regAddr == a && !$past(reset);
  endsequence
  property p_ans; regRead && !regWrite |=> regRvalid; endproperty
  property p_quiet; !(regRead && !regWrite) |=> !regRvalid; endproperty
  property p_hold; !regRvalid |-> $stable(regRdata); endproperty
  property p_one; s_rd(8'h1c) |=> regRdata == {7'h0, $past(portDetectComplete, 2)}; endproperty
  property p_two;
    s_rd(8'h1d) |=> regRdata == {($past(optimizerState, 2) == 2'h3) ? 2'h0 :
      $past(optimizerState, 2), 3'h0,
      $past({dieThermalRegulation, dataLineDetectActive, batteryPresent}, 2)};
  endproperty
  property p_three;
    s_rd(8'h1e) |=> regRdata == {$past({input2BlockingPairFitted, input1BlockingPairFitted,
      adcConversionDone & adcOneShotMode, minSystemRailRegulation & forwardMode,
      fastChargeTimerExpired, trickleTimerExpired, prechargeTimerExpired}, 2), 1'h0};
  endproperty
  property p_four;
    s_rd(8'h1f) |=> regRdata == {3'h0, $past({batteryTooLowForBoost, thermistorCold,
      thermistorCool, thermistorWarm, thermistorHot}, 2)};
  endproperty
  property p_unmap;
    regRead && !regWrite && (regAddr < 8'h1c || regAddr > 8'h1f) |=> regRdata == 8'h00;
  endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  a_quiet: assert property (p_quiet) else $error("valid without read");
  a_hold: assert property (p_hold) else $error("data moved while idle");
  a_one: assert property (p_one) else $error("status one wrong");
  a_two: assert property (p_two) else $error("status two wrong");
  a_three: assert property (p_three) else $error("status three wrong");
  a_four: assert property (p_four) else $error("status four wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
endmodule
bind csr_status_bank csr_status_bank_monitor mon (.*);

//--- csr_status_bank_tb.sv
// testbench for the status register bank
`timescale 1ns/10ps
module csr_status_bank_tb;
  reg mclk = 0, reset = 1, regRead = 0, regWrite = 0;
  reg [7:0] regAddr = 0, regWdata = 0;
  reg [19:0] c = 20'hfffff;
  wire [7:0] regRdata;
  wire regRvalid;
  integer error_cnt = 0, total_checks = 0, i, a;
  always #2.5 mclk = ~mclk;
  csr_status_bank uut (.mclk(mclk), .reset(reset), .regRead(regRead), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .portDetectComplete(c[0]), .optimizerState(c[2:1]), .dieThermalRegulation(c[3]),
    .dataLineDetectActive(c[4]), .batteryPresent(c[5]), .input2BlockingPairFitted(c[6]),
    .input1BlockingPairFitted(c[7]), .adcOneShotMode(c[8]), .adcConversionDone(c[9]),
    .forwardMode(c[10]), .minSystemRailRegulation(c[11]), .fastChargeTimerExpired(c[12]),
    .trickleTimerExpired(c[13]), .prechargeTimerExpired(c[14]),
    .batteryTooLowForBoost(c[15]), .thermistorCold(c[16]), .thermistorCool(c[17]),
    .thermistorWarm(c[18]), .thermistorHot(c[19]));
  function [7:0] model_byte(input [7:0] ad, input [19:0] v);
    case (ad)
      8'h1c: model_byte = {7'h0, v[0]};
      8'h1d: model_byte = {(v[2:1] == 2'h3) ? 2'h0 : v[2:1], 3'h0, v[3], v[4], v[5]};
      8'h1e: model_byte = {v[6], v[7], v[9] & v[8], v[11] & v[10], v[12], v[13], v[14], 1'h0};
      8'h1f: model_byte = {3'h0, v[15], v[16], v[17], v[18], v[19]};
      default: model_byte = 8'h00;
    endcase
  endfunction
  task chk(input [8:0] got, input [8:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
        error_cnt = error_cnt + 1;
      end
    end
  endtask
  task rd(input [7:0] ad);
    begin
      @(posedge mclk);
      regRead <= 1'h1;
      regAddr <= ad;
      @(posedge mclk);
      regRead <= 1'h0;
      #1 chk({regRvalid, regRdata}, {1'h1, model_byte(ad, c)});
    end
  endtask
  task stop_test;
    begin
      if (error_cnt == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #100000 error_cnt = error_cnt + 1;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge mclk);
    #1 chk({regRvalid, regRdata}, 9'h0);
    @(posedge mclk) reset <= 1'h0;
    for (i = 0; i < 22; i = i + 1) begin
      @(posedge mclk);
      c <= (i == 20) ? 20'hfffff : (20'h1 << i);
      @(posedge mclk);
      regWrite <= 1'h1;
      regAddr <= 8'h1e;
      regWdata <= 8'hff;
      @(posedge mclk);
      regWrite <= 1'h0;
      #1 chk({regRvalid, 8'h0}, 9'h0);
      for (a = 8'h1b; a <= 8'h20; a = a + 1) rd(a[7:0]);
    end
    // read and write together is not taken
    @(posedge mclk);
    c <= 20'hfffff;
    regRead <= 1'h1;
    regWrite <= 1'h1;
    regAddr <= 8'h1d;
    @(posedge mclk);
    regRead <= 1'h0;
    regWrite <= 1'h0;
    #1 chk({regRvalid, 8'h0}, 9'h0);
    rd(8'h1f);
    // reset in mid-run clears read data
    @(posedge mclk) reset <= 1'h1;
    repeat (2) @(posedge mclk);
    #1 chk({regRvalid, regRdata}, 9'h0);
    @(posedge mclk) reset <= 1'h0;
    rd(8'h1e);
    stop_test;
  end
endmodule

//--- csr_status_pack.v
// packs live condition inputs into the four status bytes
`timescale 1ns/10ps
`include "csr_consts.vh"
module csr_status_pack (
  // conditions
  input wire portDetectComplete,
  input wire [1:0] optimizerState,
  input wire dieThermalRegulation,
  input wire dataLineDetectActive,
  input wire batteryPresent,
  input wire input2BlockingPairFitted,
  input wire input1BlockingPairFitted,
  input wire adcOneShotMode,
  input wire adcConversionDone,
  input wire forwardMode,
  input wire minSystemRailRegulation,
  input wire fastChargeTimerExpired,
  input wire trickleTimerExpired,
  input wire prechargeTimerExpired,
  input wire batteryTooLowForBoost,
  input wire thermistorCold,
  input wire thermistorCool,
  input wire thermistorWarm,
  input wire thermistorHot,
  // packed bytes
  output wire [7:0] statusOne,
  output wire [7:0] statusTwo,
  output wire [7:0] statusThree,
  output wire [7:0] statusFour
);
  wire [1:0] icoSafe;
  // reserved encoding mapped to off
  assign icoSafe = (optimizerState == `CSR_ICO_RSVD) ? `CSR_ICO_OFF : optimizerState; // R2 R18
  // other status one fields lie outside this bank
  assign statusOne = {7'h00, portDetectComplete}; // R1
  assign statusTwo = {icoSafe, 3'h0, dieThermalRegulation, dataLineDetectActive,
    batteryPresent}; // R3 R4 R5 R18
  assign statusThree = {input2BlockingPairFitted, input1BlockingPairFitted, // R7 R8
    adcOneShotMode & adcConversionDone, // R9
    forwardMode & minSystemRailRegulation, // R10
    fastChargeTimerExpired, trickleTimerExpired, prechargeTimerExpired, 1'b0}; // R11 R18
  assign statusFour = {3'h0, batteryTooLowForBoost, thermistorCold, thermistorCool,
    thermistorWarm, thermistorHot}; // R12 R13 R14 R15 R16 R18
endmodule
